//--- core/degauss_request_seq_pkg.sv
// constants, pin bundle and state codes for the degauss and error sequencer
// assumes one 10 MHz clock; pins arrive raw and are synchronised in the core
// Function
// - in operation, degauss starts only after the request pin stays high 25.6 us
// - a started degauss cycle runs about 110 ms unless aborted
// - degauss timing comes from the internal clock and counters only
// - error flag is held low for the whole degauss cycle
// - request high at power-on starts degauss about 12 us after supply good
// - request low at power-on skips degauss, operation starts after 32 us
// - probe excitation keeps running during degauss
// - request low for 25 us aborts a running degauss cycle
// - after an abort, error stays low and driver off for 3.3 ms
// - four good probe cycles enable the driver and release the error flag
// - supply drops shorter than 31 us are ignored
// - supply drop longer than 100 us causes a full power-on restart
// - probe low over 32 us flags error, driver stops after the timeout
// - recovery from stuck probe holds error and driver reset for 3.3 ms
// - three short probe pulses flag error; long episodes add 3.3 ms hold
// - low coil current over 100 us flags open coil unless check disabled
// - open coil only asserts error, driver and probe keep running
// - error flag releases once no fault remains and operation resumed
// - error and over-range flags are open-drain, pull low only
// - overload recovery only while the probe loop ran uninterrupted
// - over-range flag is blanked for 3 us against transients
package degauss_request_seq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint unsigned CLK_PS = 100000;
  function automatic int unsigned cyc_min(input longint unsigned ns);
    longint unsigned c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : 32'(c);
  endfunction
  function automatic int unsigned cyc_max(input longint unsigned ns);
    longint unsigned c;
    c = (ns * 1000) / CLK_PS;
    return (c < 1) ? 1 : 32'(c);
  endfunction
  localparam longint unsigned REQ_HIGH_NS = 25600;
  localparam longint unsigned REQ_LOW_NS = 25000;
  localparam longint unsigned DEGAUSS_NS = 110000000;
  localparam longint unsigned RECOVER_NS = 3300000;
  localparam longint unsigned POR_DEGAUSS_NS = 12000;
  localparam longint unsigned POR_RUN_NS = 32000;
  localparam longint unsigned HALF_MAX_NS = 32000;
  localparam longint unsigned HALF_MIN_NS = 280;
  localparam longint unsigned BO_IGNORE_NS = 31000;
  localparam longint unsigned BO_POR_NS = 100000;
  localparam longint unsigned SHORT_LONG_NS = 25000;
  localparam longint unsigned OPEN_COIL_NS = 100000;
  localparam longint unsigned OVR_BLANK_NS = 3000;
  localparam int unsigned DEGAUSS_CYC = cyc_max(DEGAUSS_NS);
  localparam int unsigned RECOVER_CYC = cyc_min(RECOVER_NS);
  localparam logic [9:0] C_REQ_HIGH = 10'(cyc_min(REQ_HIGH_NS));
  localparam logic [9:0] C_REQ_LOW = 10'(cyc_min(REQ_LOW_NS));
  localparam logic [9:0] C_POR_DG = 10'(cyc_max(POR_DEGAUSS_NS));
  localparam logic [9:0] C_POR_RUN = 10'(cyc_max(POR_RUN_NS));
  localparam logic [9:0] C_HALF_MAX = 10'(cyc_max(HALF_MAX_NS));
  localparam logic [9:0] C_HALF_MIN = 10'(cyc_min(HALF_MIN_NS));
  localparam logic [9:0] C_BO_IGNORE = 10'(cyc_min(BO_IGNORE_NS));
  localparam logic [9:0] C_BO_POR = 10'(cyc_min(BO_POR_NS));
  localparam logic [9:0] C_SHORT_LONG = 10'(cyc_min(SHORT_LONG_NS));
  localparam logic [9:0] C_OPEN = 10'(cyc_min(OPEN_COIL_NS));
  localparam logic [9:0] C_OVR = 10'(cyc_min(OVR_BLANK_NS));
  localparam logic [9:0] C_GOOD = 10'h008;
  localparam logic [9:0] C_SHORT_N = 10'h003;
  localparam int unsigned TMR_W = 21;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_START = 3'h1,
    ST_DEGAUSS = 3'h3,
    ST_CHECK = 3'h2,
    ST_RUN = 3'h6,
    ST_PFAULT = 3'h7,
    ST_HOLD = 3'h5,
    ST_ABORT = 3'h4
  } seq_state_e;
  localparam seq_state_e ST_RESET = ST_POR;
  typedef struct packed {
    logic degauss_request;
    logic coil_check_enable;
    logic supply_ok;
    logic probe_cmp;
    logic coil_current_low;
    logic amp_overload;
  } pins_s;
endpackage

//--- core/degauss_request_error_sequencer.sv
// degauss, power-on and fault flag sequencer of a closed-loop sensor conditioner
// assumes raw asynchronous pin levels in, external pull-ups on both flag pins
module degauss_request_error_sequencer #(
  parameter int unsigned DEGAUSS_CYCLES = degauss_request_seq_pkg::DEGAUSS_CYC,
  parameter int unsigned RECOVER_CYCLES = degauss_request_seq_pkg::RECOVER_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire degauss_request_seq_pkg::pins_s pins,
  output logic error_o,
  output logic error_oe,
  output logic over_range_o,
  output logic over_range_oe,
  output logic comp_coil_driver,
  output logic probe_drive_en,
  output logic degauss_active
);
  localparam logic [20:0] DG_LIM = 21'(DEGAUSS_CYCLES);
  localparam logic [20:0] HOLD_LIM = 21'(RECOVER_CYCLES);
  localparam logic [20:0] POR_DG = 21'(degauss_request_seq_pkg::C_POR_DG);
  localparam logic [20:0] POR_RUN = 21'(degauss_request_seq_pkg::C_POR_RUN);

  function automatic logic [9:0] sat_inc(input logic [9:0] c, input logic [9:0] lim);
    return (c < lim) ? c + 10'h001 : c;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  degauss_request_seq_pkg::pins_s s1_q;
  degauss_request_seq_pkg::pins_s s2_q;
  logic probe_d3_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      probe_d3_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      probe_d3_q <= s2_q.probe_cmp;
    end
  end

  wire req = s2_q.degauss_request;
  wire supply = s2_q.supply_ok;
  wire probe_lvl = s2_q.probe_cmp;
  wire p_edge = probe_lvl ^ probe_d3_q;
  wire p_fall = p_edge & ~probe_lvl;

  // ----------------------------------------
  // counters and filters
  // ----------------------------------------
  degauss_request_seq_pkg::seq_state_e st_q;
  degauss_request_seq_pkg::seq_state_e st_d;
  logic [20:0] tmr_q;
  logic [9:0] req_hi_q;
  logic [9:0] req_lo_q;
  logic [9:0] bo_q;
  logic [9:0] hp_q;
  logic [9:0] sh_cnt_q;
  logic [9:0] sh_dur_q;
  logic [9:0] good_q;
  logic [9:0] oc_q;
  logic [9:0] ov_q;
  logic ovr_flag_q;
  logic zero_q;

  // supply watch keeps counting in reset state, it is what ends it
  wire [9:0] bo_d = supply ? 10'h000 : sat_inc(bo_q, degauss_request_seq_pkg::C_BO_POR);
  wire por_evt = ~supply & (bo_q == degauss_request_seq_pkg::C_BO_POR - 10'h001);
  // dips under the ignore time leave no trace at all
  wire bo_err = bo_q >= degauss_request_seq_pkg::C_BO_IGNORE;
  wire clr = por_evt | (st_q == degauss_request_seq_pkg::ST_POR);

  wire [9:0] req_hi_d = (clr | ~req) ? 10'h000 : sat_inc(req_hi_q, degauss_request_seq_pkg::C_REQ_HIGH);
  wire [9:0] req_lo_d = (clr | req) ? 10'h000 : sat_inc(req_lo_q, degauss_request_seq_pkg::C_REQ_LOW);
  // single pulse so a request held high does not retrigger after the cycle
  wire req_start = req & (req_hi_q == degauss_request_seq_pkg::C_REQ_HIGH - 10'h001);
  wire req_abort = ~req & (req_lo_q == degauss_request_seq_pkg::C_REQ_LOW - 10'h001);

  wire [9:0] hp_d = clr ? 10'h000 : p_edge ? 10'h001 : sat_inc(hp_q, degauss_request_seq_pkg::C_HALF_MAX);
  wire hp_timeout = hp_q == degauss_request_seq_pkg::C_HALF_MAX;
  wire stuck_low = ~probe_lvl & hp_timeout;
  wire half_ok = (hp_q >= degauss_request_seq_pkg::C_HALF_MIN) & ~hp_timeout;
  wire short_pulse = hp_q < degauss_request_seq_pkg::C_HALF_MIN;

  wire [9:0] sh_step = short_pulse ? sat_inc(sh_cnt_q, degauss_request_seq_pkg::C_SHORT_N) : 10'h000;
  wire [9:0] sh_cnt_d = clr ? 10'h000 : p_fall ? sh_step : sh_cnt_q;
  wire short_fault = sh_cnt_q == degauss_request_seq_pkg::C_SHORT_N;
  wire [9:0] sh_dur_d = (clr | ~short_fault) ? 10'h000
    : sat_inc(sh_dur_q, degauss_request_seq_pkg::C_SHORT_LONG);
  wire short_long = sh_dur_q == degauss_request_seq_pkg::C_SHORT_LONG;

  wire in_check = st_q == degauss_request_seq_pkg::ST_CHECK;
  wire [9:0] good_step = half_ok ? sat_inc(good_q, degauss_request_seq_pkg::C_GOOD) : 10'h000;
  wire [9:0] good_d = (~in_check | hp_timeout) ? 10'h000 : p_edge ? good_step : good_q;
  wire probe_good = good_q == degauss_request_seq_pkg::C_GOOD;

  wire in_run = st_q == degauss_request_seq_pkg::ST_RUN;
  wire coil_bad = in_run & s2_q.coil_check_enable & s2_q.coil_current_low;
  wire [9:0] oc_d = coil_bad ? sat_inc(oc_q, degauss_request_seq_pkg::C_OPEN) : 10'h000;
  wire open_coil = oc_q == degauss_request_seq_pkg::C_OPEN;

  wire [9:0] ov_d = s2_q.amp_overload ? sat_inc(ov_q, degauss_request_seq_pkg::C_OVR) : 10'h000;
  wire ovr_hit = ov_q == degauss_request_seq_pkg::C_OVR;
  wire loop_ok = ~stuck_low & (st_q != degauss_request_seq_pkg::ST_POR)
    & (st_q != degauss_request_seq_pkg::ST_PFAULT);
  // a latched overload only clears while the probe loop keeps running
  wire ovr_flag_d = ovr_hit | (ovr_flag_q & ~loop_ok);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bo_q <= 10'h000;
      req_hi_q <= 10'h000;
      req_lo_q <= 10'h000;
      hp_q <= 10'h000;
      sh_cnt_q <= 10'h000;
      sh_dur_q <= 10'h000;
      good_q <= 10'h000;
      oc_q <= 10'h000;
      ov_q <= 10'h000;
      ovr_flag_q <= 1'b0;
    end
    else if (ce)
    begin
      bo_q <= bo_d;
      req_hi_q <= req_hi_d;
      req_lo_q <= req_lo_d;
      hp_q <= hp_d;
      sh_cnt_q <= sh_cnt_d;
      sh_dur_q <= sh_dur_d;
      good_q <= good_d;
      oc_q <= oc_d;
      ov_q <= ov_d;
      ovr_flag_q <= ovr_flag_d;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one shared timer; all cycle lengths are counted on mclk, no outside timebase
  wire [20:0] tmr_inc = (&tmr_q) ? tmr_q : tmr_q + 21'h000001;
  wire [20:0] tmr_d = (st_d != st_q) ? 21'h000000 : tmr_inc;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      degauss_request_seq_pkg::ST_POR:
        if (supply)
          st_d = degauss_request_seq_pkg::ST_START;
      degauss_request_seq_pkg::ST_START:
        if (req && tmr_q >= POR_DG)
          st_d = degauss_request_seq_pkg::ST_DEGAUSS;
        else if (tmr_q >= POR_RUN)
          st_d = degauss_request_seq_pkg::ST_CHECK;
      degauss_request_seq_pkg::ST_DEGAUSS:
        if (req_abort)
          st_d = degauss_request_seq_pkg::ST_ABORT;
        else if (tmr_q >= DG_LIM)
          st_d = degauss_request_seq_pkg::ST_CHECK;
      degauss_request_seq_pkg::ST_ABORT:
        if (tmr_q >= HOLD_LIM)
          st_d = degauss_request_seq_pkg::ST_CHECK;
      degauss_request_seq_pkg::ST_CHECK:
        if (probe_good)
          st_d = degauss_request_seq_pkg::ST_RUN;
      degauss_request_seq_pkg::ST_RUN:
        if (stuck_low)
          st_d = degauss_request_seq_pkg::ST_PFAULT;
        else if (req_start)
          st_d = degauss_request_seq_pkg::ST_DEGAUSS;
        else if (~short_fault & short_long)
          st_d = degauss_request_seq_pkg::ST_HOLD;
      degauss_request_seq_pkg::ST_PFAULT:
        if (p_edge)
          st_d = degauss_request_seq_pkg::ST_HOLD;
      degauss_request_seq_pkg::ST_HOLD:
        if (tmr_q >= HOLD_LIM)
          st_d = degauss_request_seq_pkg::ST_RUN;
    endcase
    if (por_evt)
      st_d = degauss_request_seq_pkg::ST_POR;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q <= degauss_request_seq_pkg::ST_RESET;
      tmr_q <= 21'h000000;
    end
    else if (ce)
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // error holds in every state but run; open coil only touches the flag
  wire err_d = ~in_run | short_fault | open_coil | bo_err;
  wire drv_d = in_run | (st_q == degauss_request_seq_pkg::ST_DEGAUSS);
  wire probe_d = st_q != degauss_request_seq_pkg::ST_POR;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      error_oe <= 1'b1;
      over_range_oe <= 1'b0;
      comp_coil_driver <= 1'b0;
      probe_drive_en <= 1'b0;
      degauss_active <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (ce)
    begin
      error_oe <= err_d;
      over_range_oe <= ovr_flag_q;
      comp_coil_driver <= drv_d;
      probe_drive_en <= probe_d;
      degauss_active <= st_q == degauss_request_seq_pkg::ST_DEGAUSS;
      zero_q <= 1'b0;
    end
  end

  // pins only ever pull low, so both take the same registered zero
  assign error_o = zero_q;
  assign over_range_o = zero_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst || !ce);

  req_filter_a: assert property (
    (in_run && st_d == degauss_request_seq_pkg::ST_DEGAUSS)
    |-> (req_hi_q == degauss_request_seq_pkg::C_REQ_HIGH - 10'h001))
    else $error("degauss started before request filter time");

  degauss_len_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_DEGAUSS && st_d == degauss_request_seq_pkg::ST_CHECK)
    |-> tmr_q >= DG_LIM)
    else $error("degauss cycle ended early");

  degauss_err_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_DEGAUSS) |=> error_oe && degauss_active)
    else $error("error flag released during degauss");

  abort_filter_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_DEGAUSS && st_d == degauss_request_seq_pkg::ST_ABORT)
    |-> $past(req) == 1'b0 && req_lo_q == degauss_request_seq_pkg::C_REQ_LOW - 10'h001)
    else $error("abort taken without filtered low request");

  abort_hold_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_ABORT && st_d != st_q && !por_evt)
    |-> tmr_q >= HOLD_LIM ##1 error_oe && !comp_coil_driver)
    else $error("abort hold too short");

  power_start_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_START && st_d == degauss_request_seq_pkg::ST_CHECK)
    |-> tmr_q >= POR_RUN)
    else $error("start-up left too early");

  check_pass_a: assert property (
    (in_check && st_d == degauss_request_seq_pkg::ST_RUN) |-> good_q == degauss_request_seq_pkg::C_GOOD
    ##2 comp_coil_driver)
    else $error("driver enabled without four good probe cycles");

  stuck_probe_a: assert property (
    (in_run && stuck_low && !por_evt)
    |=> st_q == degauss_request_seq_pkg::ST_PFAULT ##1 !comp_coil_driver && error_oe)
    else $error("stuck probe did not stop driver");

  brownout_por_a: assert property (
    (bo_q == degauss_request_seq_pkg::C_BO_POR - 10'h001 && !supply) |=> st_q == degauss_request_seq_pkg::ST_POR)
    else $error("long supply drop did not restart");

  open_coil_a: assert property (
    (open_coil && in_run && !stuck_low && !por_evt && !req_start && !short_long)
    |=> error_oe && comp_coil_driver)
    else $error("open coil handling wrong");

  ovr_blank_a: assert property (
    $rose(over_range_oe) |-> $past(ovr_hit, 2))
    else $error("over-range flag not blanked");

  short_flag_a: assert property (
    (short_fault && in_run) |=> error_oe)
    else $error("short probe pulses did not flag error");

  coil_off_a: assert property (
    !s2_q.coil_check_enable |=> oc_q == 10'h000)
    else $error("coil check ran while disabled");

  probe_run_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_DEGAUSS) |=> probe_drive_en)
    else $error("probe stopped during degauss");

  pin_low_a: assert property (
    error_o == 1'b0 && over_range_o == 1'b0)
    else $error("flag pin drives high");

  dip_ignore_a: assert property (
    (bo_q < degauss_request_seq_pkg::C_BO_IGNORE && in_run && !short_fault && !open_coil)
    |=> !error_oe)
    else $error("short supply dip raised error");

  power_degauss_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_START && st_d == degauss_request_seq_pkg::ST_DEGAUSS)
    |-> tmr_q >= POR_DG && req)
    else $error("power-on degauss started wrongly");

  ovr_hold_a: assert property (
    (ovr_flag_q && !loop_ok) |=> ovr_flag_q)
    else $error("over-range cleared with probe loop broken");

  por_clear_a: assert property (
    (st_q == degauss_request_seq_pkg::ST_POR) |=> req_hi_q == 10'h000 && hp_q == 10'h000)
    else $error("filters not cleared in reset state");

  cover_por_c: cover property (por_evt);
  cover_degauss_c: cover property (st_q == degauss_request_seq_pkg::ST_DEGAUSS
    && st_d == degauss_request_seq_pkg::ST_CHECK);
  cover_abort_c: cover property (st_d == degauss_request_seq_pkg::ST_ABORT);
  cover_short_c: cover property (st_d == degauss_request_seq_pkg::ST_HOLD && in_run);
  cover_coil_c: cover property (open_coil && in_run);
endmodule

//--- verification/host_pin_model.sv
// host side model: probe comparator source and pulled-up flag wires
// assumes the bench runs the 10 MHz clock and reads the resolved wires
module host_pin_model #(
  parameter int unsigned HALF = 10
) (
  input wire logic mclk,
  input wire logic probe_run,
  input wire logic error_o,
  input wire logic error_oe,
  input wire logic over_range_o,
  input wire logic over_range_oe,
  output logic probe_cmp,
  output logic error_wire,
  output logic over_range_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // probe oscillation
  // ----------------------------------------
  int unsigned cnt = 0;
  logic probe_q = 1'b0;
  assign probe_cmp = probe_q;
  // half-period well inside the good window; stopped probe sits low like a stuck probe
  always @(posedge mclk)
  begin
    if (!probe_run)
    begin
      probe_q <= 1'b0;
      cnt <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      probe_q <= ~probe_q;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
  // ----------------------------------------
  // open-drain wires with pull-ups
  // ----------------------------------------
  // released wire goes to the pull-up level, never to the last driven value
  assign error_wire = error_oe ? error_o : 1'b1;
  assign over_range_wire = over_range_oe ? over_range_o : 1'b1;
endmodule

//--- verification/degauss_request_error_sequencer_bench.sv
// self-checking bench for the degauss and error sequencer
// assumes shortened degauss and recovery counts; ce is held high throughout
module degauss_request_error_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic cce = 1'b0;
  logic sup = 1'b0;
  logic coil_low = 1'b0;
  logic ovl = 1'b0;
  logic probe_run = 1'b1;
  logic probe;
  logic err_w;
  logic ovr_w;
  degauss_request_seq_pkg::pins_s pins_w;
  logic error_o, error_oe, over_range_o, over_range_oe;
  logic comp_coil_driver, probe_drive_en, degauss_active;
  int n_fail = 0;
  int cmp_count = 0;
  assign pins_w = {req, cce, sup, probe, coil_low, ovl};
  initial forever #50 mclk = ~mclk;
  degauss_request_error_sequencer #(.DEGAUSS_CYCLES(2000), .RECOVER_CYCLES(300)) u_degauss_request_error_sequencer (
    .mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .pins(pins_w),
    .error_o(error_o), .error_oe(error_oe), .over_range_o(over_range_o),
    .over_range_oe(over_range_oe), .comp_coil_driver(comp_coil_driver),
    .probe_drive_en(probe_drive_en), .degauss_active(degauss_active));
  host_pin_model #(.HALF(10)) u_host_pin_model (
    .mclk(mclk), .probe_run(probe_run), .error_o(error_o), .error_oe(error_oe),
    .over_range_o(over_range_o), .over_range_oe(over_range_oe), .probe_cmp(probe),
    .error_wire(err_w), .over_range_wire(ovr_w));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // inputs always move 10 ns after the rising edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return error_oe;
      1: return degauss_active;
      default: return over_range_oe;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && pick(s) !== v; i++)
      tick(1);
    cmp_count++;
    if (pick(s) !== v)
    begin
      $display("[FAIL] t=%0t wait %0d got %h exp %h", $time, s, pick(s), v);
      n_fail++;
      wrap_up();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic power_up_plain();
    chk(error_oe, 1'b1);
    chk(comp_coil_driver, 1'b0);
    sup = 1'b1;
    tick(300);
    chk(error_oe, 1'b1);
    wait_for(0, 1'b0, 700);
    chk(comp_coil_driver, 1'b1);
    chk(err_w, 1'b1);
  endtask
  task automatic degauss_full();
    req = 1'b1;
    tick(150);
    req = 1'b0; // short pulse must not start a cycle
    tick(300);
    chk(degauss_active, 1'b0);
    req = 1'b1; // held well past the filter
    tick(240);
    chk(degauss_active, 1'b0);
    wait_for(1, 1'b1, 40);
    tick(2);
    chk(error_oe, 1'b1);
    chk(err_w, 1'b0);
    chk(probe_drive_en, 1'b1);
    tick(1900);
    chk(degauss_active, 1'b1);
    wait_for(1, 1'b0, 200);
    req = 1'b0;
    wait_for(0, 1'b0, 300);
  endtask
  task automatic degauss_abort();
    req = 1'b1;
    wait_for(1, 1'b1, 300);
    tick(500);
    req = 1'b0;
    tick(200);
    chk(degauss_active, 1'b1);
    wait_for(1, 1'b0, 80);
    tick(2);
    chk(error_oe, 1'b1);
    chk(comp_coil_driver, 1'b0);
    tick(250);
    chk(error_oe, 1'b1);
    wait_for(0, 1'b0, 300);
  endtask
  task automatic stuck_probe();
    probe_run = 1'b0;
    tick(300);
    chk(error_oe, 1'b0);
    chk(comp_coil_driver, 1'b1);
    wait_for(0, 1'b1, 60);
    tick(2);
    chk(comp_coil_driver, 1'b0);
    probe_run = 1'b1;
    tick(200);
    chk(error_oe, 1'b1);
    chk(comp_coil_driver, 1'b0);
    wait_for(0, 1'b0, 300);
  endtask
  task automatic open_coil();
    cce = 1'b1;
    coil_low = 1'b1;
    tick(900);
    chk(error_oe, 1'b0);
    wait_for(0, 1'b1, 200);
    chk(comp_coil_driver, 1'b1);
    chk(probe_drive_en, 1'b1);
    coil_low = 1'b0;
    wait_for(0, 1'b0, 20);
    cce = 1'b0; // check disabled by the host
    coil_low = 1'b1;
    tick(1300);
    chk(error_oe, 1'b0);
    coil_low = 1'b0;
  endtask
  task automatic over_range();
    ovl = 1'b1;
    tick(20);
    ovl = 1'b0;
    tick(10);
    chk(over_range_oe, 1'b0);
    ovl = 1'b1;
    tick(25);
    chk(over_range_oe, 1'b0);
    wait_for(2, 1'b1, 20);
    chk(ovr_w, 1'b0);
    chk(err_w, 1'b1);
    ovl = 1'b0;
    wait_for(2, 1'b0, 20);
  endtask
  task automatic brownout();
    sup = 1'b0;
    tick(200);
    sup = 1'b1;
    tick(20);
    chk(error_oe, 1'b0);
    chk(comp_coil_driver, 1'b1);
    req = 1'b1; // restart must take the degauss path
    sup = 1'b0;
    tick(1200);
    chk(error_oe, 1'b1);
    chk(comp_coil_driver, 1'b0);
    sup = 1'b1;
    tick(100);
    chk(degauss_active, 1'b0);
    wait_for(1, 1'b1, 60);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(8);
    chk(error_oe, 1'b1);
    sys_rst = 1'b0;
    power_up_plain();
    degauss_full();
    degauss_abort();
    stuck_probe();
    open_coil();
    over_range();
    brownout();
    wrap_up();
  end
endmodule
